// ===== logic/rfs_rx_stats.sv
// Receive statistics event generator with AXI4-Lite control
`default_nettype none
module rfs_rx_stats
    import rfs_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   rst_b,
    input  wire rfs_pkg::rfs_axis_t     rx_in,
    input  wire logic                   in_fcs_bad,
    input  wire logic                   in_fcs_stomped,
    input  wire logic                   in_pre_bad,
    input  wire logic                   in_sfd_bad,
    input  wire logic                   in_sig_os,
    output rfs_pkg::rfs_axis_t          rx_out,
    output rfs_pkg::rfs_stats_t         stats,
    input  wire logic [RFS_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [RFS_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready
);
    import rfs_pkg::*;

    function automatic logic [3:0] rfs_bytes(input logic [7:0] keep);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < RFS_KEEP_W; i++)
        begin
            n = n + {3'h0, keep[i]};
        end
        return n;
    endfunction

    // Register state
    logic [31:0]           ctrl_q;
    logic [31:0]           ctrl_d;
    logic [15:0]           frames_q;
    logic                  awready_q;
    logic                  bvalid_q;
    logic [1:0]            bresp_q;
    logic                  arready_q;
    logic                  rvalid_q;
    logic [1:0]            rresp_q;
    logic [31:0]           rdata_q;

    // Frame state
    logic [RFS_DATA_W-1:0] hdr0_q;
    logic [RFS_DATA_W-1:0] hdr1_q;
    logic [1:0]            beat_q;
    logic [15:0]           len_q;
    logic                  in_frame_q;
    logic                  drop_q;
    rfs_axis_t             rx_out_q;
    rfs_axis_t             rx_out_d;
    rfs_stats_t            stats_q;
    rfs_stats_t            stats_d;
    rfs_hdr_t              hdr;

    // Control fields
    wire logic        skip_w = ctrl_q[RFS_CTRL_SKIP_BIT];
    wire logic [14:0] max_len_w =
        ctrl_q[RFS_CTRL_MAX_LSB +: RFS_MAXLEN_W];

    // Frame path decode
    wire logic        take    = rx_in.tvalid & ~drop_q;
    wire logic [3:0]  nbytes  = rfs_bytes(rx_in.tkeep);
    wire logic [16:0] len_sum = {1'b0, len_q} + {13'h0, nbytes};
    wire logic [16:0] flen    = len_sum + RFS_FCS_BYTES;
    wire logic        over    = flen > {2'h0, max_len_w};
    wire logic        cut     = take & over;
    wire logic        ev_end  = take & (rx_in.tlast | over);
    wire logic        fcs_chk = ev_end & rx_in.tlast & ~over;
    wire logic        fcs_bad_e = fcs_chk & in_fcs_bad;
    wire logic        good    = fcs_chk & ~in_fcs_bad;
    wire logic        in_range =
        (flen >= RFS_MIN_FRAME) & ~over;
    wire logic [16:0] payload = flen - RFS_HDR_FCS_BYTES;
    wire logic [16:0] len_fld = {1'h0, hdr.len_field};
    // Short frames carry pad, so a smaller field is fine at minimum size
    wire logic        len_err = hdr.is_len &
        ((len_fld > payload) |
         ((len_fld < payload) & (flen != RFS_MIN_FRAME)));

    // Second header beat may be the one arriving now
    wire logic [RFS_DATA_W-1:0] hdr0_w =
        (beat_q == 2'h0) ? rx_in.tdata : hdr0_q;
    wire logic [RFS_DATA_W-1:0] hdr1_w =
        (beat_q == 2'h1) ? rx_in.tdata :
        (beat_q == 2'h0) ? '0 : hdr1_q;

    rfs_hdr_class u_hdr_class
    (
        .beat0 (hdr0_w),
        .beat1 (hdr1_w),
        .hdr   (hdr)
    );

    always_comb
    begin
        rx_out_d        = rx_in;
        rx_out_d.tvalid = take;
        rx_out_d.tlast  = rx_in.tlast | over;
        rx_out_d.tuser  = (fcs_bad_e & ~skip_w) | over;
    end

    always_comb
    begin
        stats_d                = '0;
        stats_d.bad_fcs        = {1'b0, fcs_bad_e};
        stats_d.packet_bad_fcs = fcs_bad_e & in_range;
        stats_d.stomped_fcs    = {1'b0, fcs_chk & in_fcs_stomped};
        stats_d.unicast        = good & hdr.ucast;
        stats_d.multicast      = good & hdr.mcast;
        stats_d.broadcast      = good & hdr.bcast;
        stats_d.vlan           = good & hdr.vlan;
        stats_d.pause          = good & hdr.pause;
        stats_d.user_pause     = good & hdr.user_pause;
        stats_d.inrangeerr     = good & len_err;
        // No check enable here: reported whatever the checker does
        stats_d.bad_preamble   = in_pre_bad;
        stats_d.bad_sfd        = in_sfd_bad;
        stats_d.signal_ordered_set_seen = in_sig_os;
        stats_d.truncated      = cut;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stats_q  <= '0;
            rx_out_q <= '0;
        end
        else
        begin
            stats_q  <= stats_d;
            rx_out_q <= rx_out_d;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hdr0_q <= '0;
            hdr1_q <= '0;
        end
        else if (take && beat_q == 2'h0)
            hdr0_q <= rx_in.tdata;
        else if (take && beat_q == 2'h1)
            hdr1_q <= rx_in.tdata;
    end

    // Tail of a cut frame is discarded until its own last beat
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            beat_q     <= 2'h0;
            len_q      <= 16'h0;
            in_frame_q <= 1'b0;
            drop_q     <= 1'b0;
        end
        else if (ev_end)
        begin
            beat_q     <= 2'h0;
            len_q      <= 16'h0;
            in_frame_q <= 1'b0;
            drop_q     <= ~rx_in.tlast;
        end
        else if (take)
        begin
            beat_q     <= (beat_q == 2'h2) ? beat_q : beat_q + 2'h1;
            len_q      <= len_sum[15:0];
            in_frame_q <= 1'b1;
        end
        else if (drop_q && rx_in.tvalid && rx_in.tlast)
            drop_q     <= 1'b0;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            frames_q <= 16'h0;
        else if (ev_end)
            frames_q <= frames_q + 16'h1;
    end

    // AXI4-Lite write: address and data taken together, one at a time
    wire logic wr_take = awready_q;
    wire logic aw_go   = s_axi_awvalid & s_axi_wvalid &
                         ~awready_q & ~bvalid_q;
    wire logic wr_ctrl = s_axi_awaddr == RFS_OFF_CTRL;
    wire logic wr_ok   = wr_ctrl |
                         (s_axi_awaddr == RFS_OFF_STATUS) |
                         (s_axi_awaddr == RFS_OFF_FRAMES);
    wire logic [31:0] strb_mask = {{8{s_axi_wstrb[3]}},
                                   {8{s_axi_wstrb[2]}},
                                   {8{s_axi_wstrb[1]}},
                                   {8{s_axi_wstrb[0]}}} & RFS_CTRL_WMASK;

    assign ctrl_d = (ctrl_q & ~strb_mask) | (s_axi_wdata & strb_mask);

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            ctrl_q <= {1'b0, RFS_MAX_LEN_RST, 16'h0};
        else if (wr_take && wr_ctrl)
            ctrl_q <= ctrl_d;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            awready_q <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RFS_RESP_OKAY;
        end
        else
        begin
            awready_q <= aw_go;
            if (wr_take)
            begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_ok ? RFS_RESP_OKAY : RFS_RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    // AXI4-Lite read
    wire logic rd_take = arready_q;
    wire logic ar_go   = s_axi_arvalid & ~arready_q & ~rvalid_q;
    wire logic rd_ctrl = s_axi_araddr == RFS_OFF_CTRL;
    wire logic rd_stat = s_axi_araddr == RFS_OFF_STATUS;
    wire logic rd_frm  = s_axi_araddr == RFS_OFF_FRAMES;
    wire logic [31:0] rd_mux =
        rd_ctrl ? ctrl_q :
        rd_stat ? {30'h0, drop_q, in_frame_q} :
        rd_frm  ? {16'h0, frames_q} : 32'h0;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rresp_q   <= RFS_RESP_OKAY;
            rdata_q   <= 32'h0;
        end
        else
        begin
            arready_q <= ar_go;
            if (rd_take)
            begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_mux;
                rresp_q  <= (rd_ctrl | rd_stat | rd_frm) ?
                            RFS_RESP_OKAY : RFS_RESP_SLVERR;
            end
            else if (s_axi_rready)
                rvalid_q <= 1'b0;
        end
    end

    assign rx_out        = rx_out_q;
    assign stats         = stats_q;
    assign s_axi_awready = awready_q;
    assign s_axi_wready  = awready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    // Checks on the event outputs
    logic skip_past_q;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            skip_past_q <= 1'b0;
        else
            skip_past_q <= skip_w;
    end

    property p_fcs_count;
        @(posedge sys_clk) disable iff (!rst_b)
        stats_q.bad_fcs[0] |->
            $past(in_fcs_bad) && $past(rx_in.tlast) && !stats_q.truncated;
    endproperty
    a_fcs_count: assert property (p_fcs_count)
        else $error("crc error pulse without a detected mismatch");

    property p_fcs_mark;
        @(posedge sys_clk) disable iff (!rst_b)
        stats_q.bad_fcs[0] |->
            rx_out_q.tvalid && rx_out_q.tlast &&
            (rx_out_q.tuser == !skip_past_q);
    endproperty
    a_fcs_mark: assert property (p_fcs_mark)
        else $error("crc errored frame end not marked as set");

    property p_pkt_bad_fcs;
        @(posedge sys_clk) disable iff (!rst_b)
        stats_q.packet_bad_fcs |->
            stats_q.bad_fcs[0] && $past(flen) >= RFS_MIN_FRAME;
    endproperty
    a_pkt_bad_fcs: assert property (p_pkt_bad_fcs)
        else $error("bad fcs frame pulse outside length range");

    property p_stomped;
        @(posedge sys_clk) disable iff (!rst_b)
        $past(fcs_chk) && $past(in_fcs_stomped) |->
            stats_q.stomped_fcs == 2'h1;
    endproperty
    a_stomped: assert property (p_stomped)
        else $error("stomped fcs not reported");

    property p_dest_kind;
        @(posedge sys_clk) disable iff (!rst_b)
        $onehot0({stats_q.unicast, stats_q.multicast, stats_q.broadcast})
        && ((stats_q.unicast | stats_q.multicast | stats_q.broadcast)
            == $past(good));
    endproperty
    a_dest_kind: assert property (p_dest_kind)
        else $error("destination pulses not one per good frame");

    property p_good_only;
        @(posedge sys_clk) disable iff (!rst_b)
        (stats_q.vlan | stats_q.pause | stats_q.user_pause |
         stats_q.inrangeerr) |-> !stats_q.bad_fcs[0] &&
            !stats_q.truncated && rx_out_q.tlast && !rx_out_q.tuser;
    endproperty
    a_good_only: assert property (p_good_only)
        else $error("good frame event on an errored frame");

    property p_pause_excl;
        @(posedge sys_clk) disable iff (!rst_b)
        !(stats_q.pause && stats_q.user_pause);
    endproperty
    a_pause_excl: assert property (p_pause_excl)
        else $error("both pause kinds on one frame");

    property p_start_errs;
        @(posedge sys_clk) disable iff (!rst_b)
        (in_pre_bad ##1 stats_q.bad_preamble) or
        (!in_pre_bad ##1 !stats_q.bad_preamble);
    endproperty
    a_start_errs: assert property (p_start_errs)
        else $error("bad preamble not reported next cycle");

    property p_sfd_os;
        @(posedge sys_clk) disable iff (!rst_b)
        (in_sfd_bad || in_sig_os) |=>
            (stats_q.bad_sfd || stats_q.signal_ordered_set_seen);
    endproperty
    a_sfd_os: assert property (p_sfd_os)
        else $error("delimiter or ordered set event lost");

    property p_trunc;
        @(posedge sys_clk) disable iff (!rst_b)
        cut && !rx_in.tlast |=>
            stats_q.truncated && rx_out_q.tlast && rx_out_q.tuser &&
            drop_q;
    endproperty
    a_trunc: assert property (p_trunc)
        else $error("truncation not pulsed and marked");

endmodule
`default_nettype wire

// ===== shared/rfs_pkg.sv
// Constants and carrier types for the receive statistics event block
`default_nettype none
package rfs_pkg;

    localparam int unsigned RFS_DATA_W   = 64;
    localparam int unsigned RFS_KEEP_W   = 8;
    localparam int unsigned RFS_ADDR_W   = 8;
    localparam int unsigned RFS_MAXLEN_W = 15;

    // Register byte addresses
    localparam logic [7:0] RFS_OFF_CTRL   = 8'h00;
    localparam logic [7:0] RFS_OFF_STATUS = 8'h04;
    localparam logic [7:0] RFS_OFF_FRAMES = 8'h08;

    // Control register fields
    localparam int unsigned RFS_CTRL_SKIP_BIT = 0;
    localparam int unsigned RFS_CTRL_MAX_LSB  = 16;
    localparam logic [31:0] RFS_CTRL_WMASK    = 32'h7fff_0001;
    localparam logic [14:0] RFS_MAX_LEN_RST   = 15'h05ee;

    localparam logic [1:0] RFS_RESP_OKAY   = 2'h0;
    localparam logic [1:0] RFS_RESP_SLVERR = 2'h2;

    // Frame arithmetic, in bytes
    localparam logic [16:0] RFS_FCS_BYTES     = 17'h00004;
    localparam logic [16:0] RFS_MIN_FRAME     = 17'h00040;
    localparam logic [16:0] RFS_HDR_FCS_BYTES = 17'h00012;
    localparam logic [15:0] RFS_MAX_LEN_FIELD = 16'h05dc;

    // Header codes
    localparam logic [15:0] RFS_TYPE_VLAN  = 16'h8100;
    localparam logic [15:0] RFS_TYPE_MACC  = 16'h8808;
    localparam logic [15:0] RFS_OP_PAUSE   = 16'h0001;
    localparam logic [15:0] RFS_OP_PRIO    = 16'h0101;

    typedef struct packed {
        logic [RFS_DATA_W-1:0] tdata;
        logic [RFS_KEEP_W-1:0] tkeep;
        logic                  tlast;
        logic                  tuser;
        logic                  tvalid;
    } rfs_axis_t;

    typedef struct packed {
        logic        bcast;
        logic        mcast;
        logic        ucast;
        logic        vlan;
        logic        pause;
        logic        user_pause;
        logic        is_len;
        logic [15:0] len_field;
    } rfs_hdr_t;

    typedef struct packed {
        logic [1:0] bad_fcs;
        logic       packet_bad_fcs;
        logic [1:0] stomped_fcs;
        logic       unicast;
        logic       multicast;
        logic       broadcast;
        logic       vlan;
        logic       pause;
        logic       user_pause;
        logic       inrangeerr;
        logic       bad_preamble;
        logic       bad_sfd;
        logic       signal_ordered_set_seen;
        logic       truncated;
    } rfs_stats_t;

endpackage
`default_nettype wire

// ===== logic/rfs_hdr_class.sv
// Header classifier: destination kind, VLAN, pause and length field
`default_nettype none
module rfs_hdr_class
    import rfs_pkg::*;
(
    input  wire logic [RFS_DATA_W-1:0] beat0,
    input  wire logic [RFS_DATA_W-1:0] beat1,
    output rfs_pkg::rfs_hdr_t          hdr
);
    import rfs_pkg::*;

    // Byte n of the frame sits in bits [8n+7:8n]
    wire logic [47:0] dest_addr = beat0[47:0];
    wire logic [15:0] ether_type = {beat1[39:32], beat1[47:40]};
    wire logic [15:0] opcode     = {beat1[55:48], beat1[63:56]};
    wire logic        is_bcast   = &dest_addr;
    wire logic        is_group   = dest_addr[0];
    wire logic        is_macc    = ether_type == RFS_TYPE_MACC;

    assign hdr.bcast      = is_bcast;
    assign hdr.mcast      = is_group & ~is_bcast;
    assign hdr.ucast      = ~is_group;
    assign hdr.vlan       = ether_type == RFS_TYPE_VLAN;
    assign hdr.pause      = is_macc & (opcode == RFS_OP_PAUSE);
    assign hdr.user_pause = is_macc & (opcode == RFS_OP_PRIO);
    assign hdr.is_len     = ether_type <= RFS_MAX_LEN_FIELD;
    assign hdr.len_field  = ether_type;

endmodule
`default_nettype wire

// ===== dv/rfs_cnt_model.sv
// Counter model of the statistics consumer on the far side
`default_nettype none
module rfs_cnt_model
(
    input  wire logic                sys_clk,
    input  wire logic                rst_b,
    input  wire rfs_pkg::rfs_stats_t stats,
    output var int                   n_fcs,
    output var int                   n_dst,
    output var int                   n_cut
);
    import rfs_pkg::*;

    // Adds the field value, so a stray 2 on the bus counts twice
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            n_fcs <= 0;
            n_dst <= 0;
            n_cut <= 0;
        end
        else
        begin
            n_fcs <= n_fcs + int'(stats.bad_fcs);
            n_dst <= n_dst + int'(stats.unicast) + int'(stats.multicast)
                     + int'(stats.broadcast);
            n_cut <= n_cut + int'(stats.truncated);
        end
    end
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the receive statistics block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rfs_pkg::*;

    typedef struct packed {
        rfs_stats_t s;
        logic       u;
    } rfs_note_t;

    localparam logic [47:0] UC = 48'h02_00_00_00_00_01;
    localparam logic [47:0] MC = 48'h01_80_c2_00_00_01;

    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    rfs_axis_t   rx_in = '0;
    rfs_axis_t   rx_out;
    rfs_stats_t  stats;
    logic        in_fcs_bad = 1'b0, in_fcs_stomped = 1'b0;
    logic        in_pre_bad = 1'b0, in_sfd_bad = 1'b0, in_sig_os = 1'b0;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = '0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [14:0] maxlen = RFS_MAX_LEN_RST;
    logic        skip = 1'b0;
    rfs_note_t   q[$];
    rfs_axis_t   rx_seen;
    int          fails = 0, checks_done = 0, seed_r;
    int          e_fcs = 0, e_dst = 0, e_cut = 0, n_fcs, n_dst, n_cut;

    always #5 sys_clk = ~sys_clk;

    // Beat the design took at the last edge, for the pass-through check
    always @(posedge sys_clk)
        rx_seen <= rx_in;

    rfs_rx_stats u_rfs_rx_stats (
        .sys_clk, .rst_b, .rx_in, .in_fcs_bad, .in_fcs_stomped,
        .in_pre_bad, .in_sfd_bad, .in_sig_os, .rx_out, .stats,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready
    );

    rfs_cnt_model u_rfs_cnt_model (
        .sys_clk, .rst_b, .stats, .n_fcs, .n_dst, .n_cut
    );

    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    task automatic end_sim;
        $display("checks_done %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ta && tw))
        begin
            @(posedge sys_clk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
            ta = ta || s_axi_awready === 1'b1;
            tw = tw || s_axi_wready === 1'b1;
        end
        do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
        chk(s_axi_bresp === er, "write response");
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata === ed && s_axi_rresp === er, "read data");
        s_axi_rready <= 1'b0;
    endtask

    // Frame of n bytes without FCS; beats follow the previous frame directly
    task automatic send(input logic [47:0] dst, input logic [15:0] ty,
                        input logic [15:0] w, input int n,
                        input logic bad, input logic stp);
        rfs_note_t  e;
        int         nb, idx;
        logic [7:0] by;
        logic       cut, good;
        nb = (n + 7) / 8;
        cut = (n + 4) > int'(maxlen);
        good = !bad && !cut;
        e = '0;
        e.u = cut || (bad && !skip);
        e.s.truncated = cut;
        if (!cut)
        begin
            e.s.bad_fcs = {1'b0, bad};
            e.s.stomped_fcs = {1'b0, stp};
            e.s.packet_bad_fcs = bad && n + 4 >= 64 && n + 4 <= int'(maxlen);
            e.s.broadcast = good && (&dst);
            e.s.multicast = good && dst[40] && !(&dst);
            e.s.unicast = good && !dst[40];
            e.s.vlan = good && ty == RFS_TYPE_VLAN;
            e.s.pause = good && ty == RFS_TYPE_MACC && w == RFS_OP_PAUSE;
            e.s.user_pause = good && ty == RFS_TYPE_MACC && w == RFS_OP_PRIO;
            // Pad allows a short field at minimum frame size
            e.s.inrangeerr = good && ty <= 16'd1500 &&
                (int'(ty) > n - 14 || (int'(ty) < n - 14 && n + 4 != 64));
        end
        e_fcs += int'(bad && !cut);
        e_dst += int'(good);
        e_cut += int'(cut);
        q.push_back(e);
        for (int i = 0; i < nb; i++)
        begin
            @(posedge sys_clk);
            for (int k = 0; k < 8; k++)
            begin
                idx = i * 8 + k;
                by = 8'($urandom);
                if (idx < 6)
                    by = dst[47 - 8 * idx -: 8];
                else if (idx > 11 && idx < 14)
                    by = ty[8 * (13 - idx) +: 8];
                else if (idx > 13 && idx < 16)
                    by = w[8 * (15 - idx) +: 8];
                else if (idx > 15 && idx < 18)
                    by = 8'haa;
                rx_in.tdata[8 * k +: 8] <= by;
                rx_in.tkeep[k] <= idx < n;
            end
            rx_in.tvalid <= 1'b1;
            rx_in.tlast <= i == nb - 1;
            in_fcs_bad <= bad && i == nb - 1;
            in_fcs_stomped <= stp && i == nb - 1;
        end
    endtask

    task automatic idle;
        @(posedge sys_clk);
        rx_in.tvalid <= 1'b0;
        rx_in.tlast <= 1'b0;
        in_fcs_bad <= 1'b0;
        in_fcs_stomped <= 1'b0;
    endtask

    task automatic pulse(input int j);
        rfs_note_t e;
        e = '0;
        e.s.bad_preamble = j == 0;
        e.s.bad_sfd = j == 1;
        e.s.signal_ordered_set_seen = j == 2;
        q.push_back(e);
        @(posedge sys_clk);
        in_pre_bad <= j == 0;
        in_sfd_bad <= j == 1;
        in_sig_os <= j == 2;
        @(posedge sys_clk);
        in_pre_bad <= 1'b0;
        in_sfd_bad <= 1'b0;
        in_sig_os <= 1'b0;
    endtask

    // Oldest note is matched against each result once outputs settle
    always @(negedge sys_clk)
    begin
        rfs_note_t n;
        if (rst_b && rx_out.tvalid)
            chk(rx_out.tdata === rx_seen.tdata &&
                rx_out.tkeep === rx_seen.tkeep, "beat copy");
        if (rst_b && (stats != '0 || (rx_out.tvalid && rx_out.tlast)))
        begin
            if (q.size() == 0)
                chk(1'b0, "result with no note");
            else
            begin
                n = q.pop_front();
                chk(stats === n.s, "stats pulse");
                chk(!rx_out.tlast || rx_out.tuser === n.u, "tuser");
            end
        end
    end

    // Whole run is under 500 cycles; thirty times that is a hang
    initial
    begin
        #150us;
        fails++;
        end_sim();
    end

    initial
    begin
        seed_r = $urandom(10);
        repeat (5) @(posedge sys_clk);
        chk(stats === '0 && rx_out.tvalid === 1'b0, "reset state");
        rst_b <= 1'b1;
        axi_rd(RFS_OFF_CTRL, {1'b0, RFS_MAX_LEN_RST, 16'h0000},
               RFS_RESP_OKAY);
        axi_rd(8'h40, 32'h0000_0000, RFS_RESP_SLVERR);
        axi_wr(RFS_OFF_STATUS, 32'hffff_ffff, RFS_RESP_OKAY);
        axi_rd(RFS_OFF_STATUS, 32'h0000_0000, RFS_RESP_OKAY);
        send(UC, 16'h0800, 16'h0000, 60, 1'b0, 1'b0);
        send(MC, 16'h0800, 16'h0000, 61, 1'b0, 1'b0);
        send('1, 16'h0800, 16'h0000, 67, 1'b0, 1'b0);
        send(UC, 16'h0800, 16'h0000, 60, 1'b1, 1'b0);
        send(UC, 16'h0800, 16'h0000, 56, 1'b1, 1'b0);
        send(UC, 16'h0800, 16'h0000, 1514, 1'b1, 1'b0);
        repeat (2) send(UC, 16'h0800, 16'h0000, 60, 1'b1, 1'b1);
        send(UC, RFS_TYPE_VLAN, 16'($urandom), 64, 1'b0, 1'b0);
        send(MC, RFS_TYPE_MACC, RFS_OP_PAUSE, 60, 1'b0, 1'b0);
        send(MC, RFS_TYPE_MACC, RFS_OP_PRIO, 60, 1'b0, 1'b0);
        send(UC, 16'd20, 16'h0000, 100, 1'b0, 1'b0);
        send(UC, 16'd86, 16'h0000, 100, 1'b0, 1'b0);
        send(UC, 16'd20, 16'h0000, 60, 1'b0, 1'b0);
        idle();
        for (int j = 0; j < 3; j++)
            pulse(j);
        skip = 1'b1;
        axi_wr(RFS_OFF_CTRL, 32'h05ee_0001, RFS_RESP_OKAY);
        send(UC, 16'h0800, 16'h0000, 70, 1'b1, 1'b0);
        idle();
        skip = 1'b0;
        maxlen = 15'd100;
        axi_wr(RFS_OFF_CTRL, 32'h0064_0000, RFS_RESP_OKAY);
        axi_rd(RFS_OFF_CTRL, 32'h0064_0000, RFS_RESP_OKAY);
        send(UC, 16'h0800, 16'h0000, 96, 1'b1, 1'b0);
        repeat (2) send(UC, 16'h0800, 16'h0000, 120, 1'b0, 1'b0);
        idle();
        repeat (20) @(posedge sys_clk);
        chk(q.size() == 0, "notes left over");
        chk(n_fcs == e_fcs && n_cut == e_cut, "event totals");
        chk(n_dst == e_dst, "address totals");
        // Event held at the input: only reset can keep the outputs at zero
        in_sig_os <= 1'b1;
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(stats === '0 && rx_out.tvalid === 1'b0, "reset hold");
        end_sim();
    end
endmodule
`default_nettype wire
